// [core/mrr_pkg.sv]
// Constants shared by the measurement register readout block.
// Assumes a single 25 MHz clock and an asynchronous active-low reset.
//
// Notes on behaviour
// - Range bit picks 2 mV or 6 mV steps.
// - High-voltage input steps 8 mV or 16 mV.
// - Five-bit selector maps thirteen legal input codes.
// - Writing ADC selection starts a conversion.
// - Pending set while request awaits converter.
// - Active while converting, cleared on copy.
// - Done reads 0 converting, 1 complete.
// - Result bits 12..5 fill high byte.
// - Averaging runs apart from single conversions.
// - Average is sample/8 plus 7/8 old.
// - Separate enables b5 and b2 per channel.
// - Interval field picks 1, 2, 4, 8 ms.
// - Readout code 00 standard, 11 high-voltage.
// - Ten-bit average split over 0x05 and 0x06.
// - Readout selection persists, result stays live.
// - Average readable at once, settles later.
// - Four-bit field picks status group shown.
// - Valid bit set when record holds group and link_ok is high.
// - Record refreshes while selection unchanged.
// - Range b7, b6-b5 zero, selector b4-b0.
// - Low byte: result, pending, active, done.
// - Read returns consecutive bytes, host NACK ends.
package mrr_pkg;
  // Link instructions and device address
  localparam logic [6:0] DEV_ADDR = 7'h2A; // Arbitrary value
  localparam logic [7:0] INSTR_WR = 8'h51;
  localparam logic [7:0] INSTR_RD = 8'h52;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Register offsets
  localparam logic [7:0] ADR_ADC_SEL = 8'h00;
  localparam logic [7:0] ADR_ADC_LO = 8'h01;
  localparam logic [7:0] ADR_ADC_HI = 8'h02;
  localparam logic [7:0] ADR_AVG_CTL = 8'h03;
  localparam logic [7:0] ADR_AVG_SEL = 8'h04;
  localparam logic [7:0] ADR_AVG_LO = 8'h05;
  localparam logic [7:0] ADR_AVG_HI = 8'h06;
  localparam logic [7:0] ADR_MON_SEL = 8'h07;
  localparam logic [7:0] ADR_MON_REC = 8'h08;
  // Field positions
  localparam int RANGE_BIT = 7;
  localparam int HV_EN_BIT = 5;
  localparam int CUR_EN_BIT = 2;
  localparam int VALID_BIT = 7;
  // Channel codes
  localparam logic [4:0] CH_V_LAST = 5'h08;
  localparam logic [4:0] CH_HV = 5'h09;
  localparam logic [4:0] CH_SUPPLY = 5'h0C;
  localparam logic [4:0] CH_CUR = 5'h10;
  localparam logic [4:0] CH_HV_CUR = 5'h13;
  // Step sizes in microvolts
  localparam logic [15:0] STEP_V_LO = 16'h07D0;
  localparam logic [15:0] STEP_V_HI = 16'h1770;
  localparam logic [15:0] STEP_HV_LO = 16'h1F40;
  localparam logic [15:0] STEP_HV_HI = 16'h3E80;
  // Averaging
  localparam logic [1:0] SEL_CUR = 2'h0;
  localparam logic [1:0] SEL_HV = 2'h3;
  localparam int AVG_SHIFT = 3;
  localparam int SAMPLE_BASE_US = 1000;
  localparam int CLK_MHZ = 25;
  localparam int SAMPLE_BASE_CYC = SAMPLE_BASE_US * CLK_MHZ;
  // Status groups
  localparam int MON_GROUPS = 7;
endpackage

// [core/mrr_bus_if.sv]
// Byte-level carrier between the serial engine and the register file.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mrr_bus_if;
  logic sta;
  logic sto;
  logic rx_stb;
  logic [7:0] rx_data;
  logic rd_stb;
  logic [7:0] tx_data;
  modport eng (output sta, sto, rx_stb, rx_data, rd_stb, input tx_data);
  modport regs (input sta, sto, rx_stb, rx_data, rd_stb, output tx_data);
endinterface

// [core/mrr_i2c_eng.sv]
// Serial byte engine: start/stop detect, address match, byte shift and acknowledge.
// Assumes the serial clock is slow against clk; pins are synchronised here.
`timescale 1ns/1ps
module mrr_i2c_eng import mrr_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  mrr_bus_if.eng bus
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX} mrr_eng_e;
  mrr_eng_e st_reg;
  logic [1:0] scl_s_reg, sda_s_reg;
  logic scl_d_reg, sda_d_reg;
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;
  logic ack_reg, sta_reg, sto_reg, rx_reg, rd_reg;
  // ************************************
  // Pin synchronisers and edge finding
  // ************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s_reg <= 2'h3;
      sda_s_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_s_reg <= {scl_s_reg[0], scl_in};
      sda_s_reg <= {sda_s_reg[0], sda_in};
      scl_d_reg <= scl_s_reg[1];
      sda_d_reg <= sda_s_reg[1];
    end
  end
  wire scl = scl_s_reg[1];
  wire sda = sda_s_reg[1];
  wire scl_rise = scl && !scl_d_reg;
  wire scl_fall = !scl && scl_d_reg;
  wire start_c = scl && scl_d_reg && !sda && sda_d_reg;
  wire stop_c = scl && scl_d_reg && sda && !sda_d_reg;
  wire full = (cnt_reg == BYTE_BITS);
  wire addr_hit = (sh_reg[7:1] == DEV_ADDR);
  // ************************************
  // Byte sequencer
  // ************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= S_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      sda_oe <= 1'b0;
      sta_reg <= 1'b0;
      sto_reg <= 1'b0;
      rx_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      sta_reg <= start_c;
      sto_reg <= stop_c;
      rx_reg <= 1'b0;
      rd_reg <= 1'b0;
      if (start_c) begin
        st_reg <= S_ADDR;
        cnt_reg <= 4'h0;
        ack_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        st_reg <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise && st_reg != S_IDLE) begin
        if (st_reg != S_TX && !ack_reg) begin
          sh_reg <= {sh_reg[6:0], sda};
          cnt_reg <= cnt_reg + 4'h1;
        end else if (st_reg == S_TX && ack_reg && sda) begin
          st_reg <= S_IDLE; // Host NACK ends the read
        end
      end else if (scl_fall) begin
        unique case (st_reg)
          S_IDLE: begin
            sda_oe <= 1'b0;
          end
          S_ADDR, S_RX: begin
            if (!ack_reg && full) begin
              if (st_reg == S_ADDR && !addr_hit) begin
                st_reg <= S_IDLE;
              end else begin
                ack_reg <= 1'b1;
                sda_oe <= 1'b1;
                rx_reg <= (st_reg == S_RX);
              end
            end else if (ack_reg) begin
              ack_reg <= 1'b0;
              cnt_reg <= 4'h0;
              sda_oe <= 1'b0;
              if (st_reg == S_ADDR && sh_reg[0]) begin
                st_reg <= S_TX;
                sh_reg <= bus.tx_data;
                sda_oe <= !bus.tx_data[7];
                cnt_reg <= 4'h1;
                rd_reg <= 1'b1;
              end else begin
                st_reg <= S_RX;
              end
            end
          end
          S_TX: begin
            if (ack_reg) begin
              ack_reg <= 1'b0; // Next consecutive byte
              sh_reg <= bus.tx_data;
              sda_oe <= !bus.tx_data[7];
              cnt_reg <= 4'h1;
              rd_reg <= 1'b1;
            end else if (full) begin
              ack_reg <= 1'b1;
              sda_oe <= 1'b0;
            end else begin
              sh_reg <= {sh_reg[6:0], 1'b0};
              sda_oe <= !sh_reg[6];
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        endcase
      end
    end
  end
  // Byte events to the register file
  assign bus.sta = sta_reg;
  assign bus.sto = sto_reg;
  assign bus.rx_stb = rx_reg;
  assign bus.rx_data = sh_reg;
  assign bus.rd_stb = rd_reg;
endmodule

// [core/mrr_top.sv]
// Measurement register file: conversion control, current averaging, status groups.
// Assumes converter handshakes and status groups arrive on clk; pins are asynchronous.
`timescale 1ns/1ps
module mrr_top import mrr_pkg::*; #(
  parameter int BASE_CYC = SAMPLE_BASE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic adc_start_reg,
  output logic [4:0] adc_chan_reg,
  output logic adc_range_reg,
  output logic [15:0] adc_step_reg,
  input wire logic adc_begin,
  input wire logic adc_end,
  input wire logic [12:0] adc_data,
  input wire logic [9:0] cur_sample,
  input wire logic [9:0] hv_sample,
  input wire logic [MON_GROUPS*8-1:0] mon_groups,
  input wire logic link_ok
);
  mrr_bus_if bus ();
  logic oe_w;
  mrr_i2c_eng u_eng (
    .clk(clk),
    .arst_n(arst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(oe_w),
    .bus(bus)
  );
  // Open-drain pin only ever pulls low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= oe_w;
    end
  end
  // ************************************
  // Transaction decode
  // ************************************
  logic [7:0] instr_reg, ptr_reg;
  logic [1:0] idx_reg;
  wire wr_any = bus.rx_stb && idx_reg[1] && instr_reg == INSTR_WR;
  wire wr_adc = wr_any && ptr_reg == ADR_ADC_SEL;
  wire wr_ctl = wr_any && ptr_reg == ADR_AVG_CTL;
  wire wr_asel = wr_any && ptr_reg == ADR_AVG_SEL;
  wire wr_mon = wr_any && ptr_reg == ADR_MON_SEL;
  // Byte index: instruction, register address, then data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_reg <= 8'h00;
      ptr_reg <= 8'h00;
      idx_reg <= 2'h0;
    end else begin
      if (bus.sta) begin
        idx_reg <= 2'h0;
      end else if (bus.rx_stb) begin
        if (idx_reg == 2'h0) begin
          instr_reg <= bus.rx_data;
        end
        if (idx_reg == 2'h1) begin
          ptr_reg <= bus.rx_data;
        end
        if (!idx_reg[1]) begin
          idx_reg <= idx_reg + 2'h1;
        end
      end
      if (wr_any || (bus.rd_stb && instr_reg == INSTR_RD)) begin
        ptr_reg <= ptr_reg + 8'h01; // Consecutive register bytes
      end
    end
  end
  // ************************************
  // Single conversion control
  // ************************************
  logic pend_reg, act_reg, done_reg;
  logic [12:0] res_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_chan_reg <= 5'h00;
      adc_range_reg <= 1'b0;
      adc_start_reg <= 1'b0;
      pend_reg <= 1'b0;
      act_reg <= 1'b0;
      done_reg <= 1'b0;
      res_reg <= 13'h0000;
    end else begin
      adc_start_reg <= wr_adc; // Write alone starts a conversion
      if (wr_adc) begin
        adc_range_reg <= bus.rx_data[RANGE_BIT];
        adc_chan_reg <= bus.rx_data[4:0];
        pend_reg <= 1'b1;
        act_reg <= 1'b0;
        done_reg <= 1'b0;
      end else if (pend_reg && adc_begin) begin
        pend_reg <= 1'b0;
        act_reg <= 1'b1;
      end else if (act_reg && adc_end) begin
        res_reg <= adc_data;
        act_reg <= 1'b0;
        done_reg <= 1'b1;
      end
    end
  end
  // Step size for the chosen input and range
  wire ch_volt = adc_chan_reg <= CH_V_LAST || adc_chan_reg == CH_SUPPLY;
  wire ch_hv = adc_chan_reg == CH_HV;
  wire ch_cur = adc_chan_reg == CH_CUR || adc_chan_reg == CH_HV_CUR;
  wire [15:0] step_v = adc_range_reg ? STEP_V_HI : STEP_V_LO;
  wire [15:0] step_hv = adc_range_reg ? STEP_HV_HI : STEP_HV_LO;
  // Unlisted codes give no step; host must avoid them
  wire [15:0] step_sel = ch_hv ? step_hv : ((ch_volt || ch_cur) ? step_v : 16'h0000);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_step_reg <= 16'h0000;
    end else begin
      adc_step_reg <= step_sel;
    end
  end
  // ************************************
  // Current averaging
  // ************************************
  logic [1:0] intv_reg, asel_reg;
  logic [1:0] en_reg;
  logic [15:0] base_reg;
  logic [2:0] ms_reg;
  wire ms_tick = base_reg == 16'(BASE_CYC - 1);
  wire [2:0] intv_mask = 3'((4'h1 << intv_reg) - 4'h1);
  wire samp_tick = ms_tick && (ms_reg & intv_mask) == intv_mask;
  // Control registers and interval timer, apart from conversions
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intv_reg <= 2'h0;
      asel_reg <= 2'h0;
      en_reg <= 2'h0;
      base_reg <= 16'h0000;
      ms_reg <= 3'h0;
    end else begin
      base_reg <= ms_tick ? 16'h0000 : base_reg + 16'h0001;
      if (ms_tick) begin
        ms_reg <= ms_reg + 3'h1;
      end
      if (wr_ctl) begin
        intv_reg <= bus.rx_data[1:0];
        en_reg <= {bus.rx_data[HV_EN_BIT], bus.rx_data[CUR_EN_BIT]};
      end
      if (wr_asel) begin
        asel_reg <= bus.rx_data[1:0]; // Held until rewritten
      end
    end
  end
  logic [12:0] acc_reg [2];
  wire [9:0] samp [2];
  assign samp[0] = cur_sample;
  assign samp[1] = hv_sample;
  // Accumulator holds eight times the average
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_avg
      wire [12:0] acc_next = acc_reg[g] - (acc_reg[g] >> AVG_SHIFT) + 13'(samp[g]);
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          acc_reg[g] <= 13'h0000;
        end else if (!en_reg[g]) begin
          acc_reg[g] <= 13'h0000;
        end else if (samp_tick) begin
          acc_reg[g] <= acc_next;
        end
      end
    end
  endgenerate
  // Selected live average, readable from enable onward
  wire [9:0] avg_cur = acc_reg[0][12:AVG_SHIFT];
  wire [9:0] avg_hv = acc_reg[1][12:AVG_SHIFT];
  wire [9:0] avg_sel = asel_reg == SEL_HV ? avg_hv : (asel_reg == SEL_CUR ? avg_cur : 10'h000);
  // ************************************
  // Status group record
  // ************************************
  logic [1:0] link_s_reg;
  logic [3:0] msel_reg;
  logic [7:0] rec_reg;
  logic fresh_reg;
  wire [7:0] grp = msel_reg < 4'(MON_GROUPS) ? mon_groups[msel_reg*8 +: 8] : 8'h00;
  wire valid = fresh_reg && link_s_reg[1];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_s_reg <= 2'h0;
      msel_reg <= 4'h0;
      rec_reg <= 8'h00;
      fresh_reg <= 1'b0;
    end else begin
      link_s_reg <= {link_s_reg[0], link_ok};
      if (wr_mon) begin
        msel_reg <= bus.rx_data[3:0];
      end
      rec_reg <= grp;
      fresh_reg <= !wr_mon;
    end
  end
  // ************************************
  // Read data, only listed bits visible
  // ************************************
  wire [7:0] rd_adc_sel = {adc_range_reg, 2'h0, adc_chan_reg};
  wire [7:0] rd_adc_lo = {res_reg[4:0], pend_reg, act_reg, done_reg};
  wire [7:0] rd_adc_hi = res_reg[12:5];
  wire [7:0] rd_ctl = {2'h0, en_reg[1], 2'h0, en_reg[0], intv_reg};
  wire [7:0] rd_avg_hi = {6'h00, avg_sel[9:8]};
  wire [7:0] rd_mon = {valid, 3'h0, msel_reg};
  assign bus.tx_data = instr_reg != INSTR_RD ? 8'h00 :
    ptr_reg == ADR_ADC_SEL ? rd_adc_sel :
    ptr_reg == ADR_ADC_LO ? rd_adc_lo :
    ptr_reg == ADR_ADC_HI ? rd_adc_hi :
    ptr_reg == ADR_AVG_CTL ? rd_ctl :
    ptr_reg == ADR_AVG_SEL ? {6'h00, asel_reg} :
    ptr_reg == ADR_AVG_LO ? avg_sel[7:0] :
    ptr_reg == ADR_AVG_HI ? rd_avg_hi :
    ptr_reg == ADR_MON_SEL ? rd_mon :
    ptr_reg == ADR_MON_REC ? rec_reg : 8'h00;
  // ************************************
  // Checks
  // ************************************
  a_write_starts: assert property (@(posedge clk) disable iff (!arst_n)
    wr_adc |=> adc_start_reg && pend_reg && !done_reg ##1 !adc_start_reg)
    else $error("conversion not started by write");
  a_pend_to_active: assert property (@(posedge clk) disable iff (!arst_n)
    pend_reg && adc_begin && !wr_adc |=> act_reg && !pend_reg)
    else $error("pending did not become active");
  a_result_copy: assert property (@(posedge clk) disable iff (!arst_n)
    act_reg && adc_end && !wr_adc |=> done_reg && !act_reg && res_reg == $past(adc_data))
    else $error("result copy wrong");
  a_done_low_busy: assert property (@(posedge clk) disable iff (!arst_n)
    (pend_reg || act_reg) |-> !done_reg)
    else $error("done set while converting");
  a_high_byte: assert property (@(posedge clk) disable iff (!arst_n)
    instr_reg == INSTR_RD && ptr_reg == ADR_ADC_HI |-> bus.tx_data == res_reg[12:5])
    else $error("high byte wrong");
  a_avg_update: assert property (@(posedge clk) disable iff (!arst_n)
    samp_tick && en_reg[0] && !wr_ctl |=>
      acc_reg[0] == $past(acc_reg[0]) - ($past(acc_reg[0]) >> AVG_SHIFT) + 13'($past(cur_sample)))
    else $error("average step wrong");
  a_avg_off_zero: assert property (@(posedge clk) disable iff (!arst_n)
    !en_reg[1] && !wr_ctl |=> acc_reg[1] == 13'h0000)
    else $error("disabled channel averaging");
  a_interval_gap: assert property (@(posedge clk) disable iff (!arst_n)
    samp_tick |-> base_reg == 16'(BASE_CYC - 1) && (intv_reg == 2'h0 || ms_reg[0]) &&
      (intv_reg < 2'h2 || ms_reg[1]) && (intv_reg != 2'h3 || ms_reg[2]))
    else $error("sample off its interval");
  a_mon_valid: assert property (@(posedge clk) disable iff (!arst_n)
    wr_mon |=> !valid ##1 (valid == link_s_reg[1]))
    else $error("valid bit wrong after select");
  a_record_live: assert property (@(posedge clk) disable iff (!arst_n)
    !wr_mon && $stable(msel_reg) && msel_reg < 4'(MON_GROUPS) |=>
      rec_reg == $past(mon_groups[msel_reg*8 +: 8]))
    else $error("record not refreshed");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    ptr_reg == ADR_AVG_HI |-> bus.tx_data[7:2] == 6'h00)
    else $error("reserved bits not zero");
endmodule

// [verification/mrr_i2c_master.sv]
// Serial bus master model that reaches the register file.
// Assumes a pull-up on the data line; oe high pulls it low.
`timescale 1ns/1ps
module mrr_i2c_master import mrr_pkg::*; (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic oe
);
  // ****************************************
  // Bit and byte framing
  // ****************************************
  // Bus idles released with the clock high
  initial begin
    scl = 1'b1;
    oe = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One bit: 160 ns low, 160 ns high, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    oe = ~b;
    hold(2);
    scl = 1'b1;
    hold(3);
    r = sda;
    hold(1);
    scl = 1'b0;
    hold(2);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    oe = 1'b0;
    hold(2);
    scl = 1'b1;
    hold(2);
    oe = 1'b1;
    hold(2);
    scl = 1'b0;
    hold(2);
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    oe = 1'b1;
    hold(2);
    scl = 1'b1;
    hold(2);
    oe = 1'b0;
    hold(4);
  endtask

  // Send a byte MSB first; ok drops on a missing acknowledge
  task automatic put(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ok = ok & ~r;
  endtask

  // Receive a byte; last answers with a NACK
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask

  // ****************************************
  // Register transfers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    put({DEV_ADDR, 1'b0}, ok);
    put(INSTR_WR, ok);
    put(a, ok);
    put(d, ok);
    stop();
  endtask

  // Two consecutive bytes, NACK on the last, then stop
  task automatic rd(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1, output logic ok);
    ok = 1'b1;
    start();
    put({DEV_ADDR, 1'b0}, ok);
    put(INSTR_RD, ok);
    put(a, ok);
    start();
    put({DEV_ADDR, 1'b1}, ok);
    get(1'b0, d0);
    get(1'b1, d1);
    stop();
  endtask
endmodule

// [verification/tb_mrr_top.sv]
// Self-checking bench for the measurement register readout block.
// Assumes the serial master model; converter and status inputs are driven here.
`timescale 1ns/1ps
module tb_mrr_top import mrr_pkg::*;;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int BASE = 40;
  localparam int MW = MON_GROUPS * 8;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl, m_oe, sda_oe, sda_out, sda, ok;
  logic adc_start_reg, adc_range_reg;
  logic [4:0] adc_chan_reg;
  logic [15:0] adc_step_reg;
  logic adc_begin = 1'b0;
  logic adc_end = 1'b0;
  logic link_ok = 1'b0;
  logic [12:0] adc_data = 13'h0000;
  logic [9:0] cur_sample = 10'h000;
  logic [9:0] hv_sample = 10'h000;
  logic [MW-1:0] mon_groups = '0;
  logic [7:0] d0, d1;
  int error_cnt = 0;
  int cmp_count = 0;
  int starts = 0;
  integer seed = 32'h95473608;
  // Legal selector codes only
  logic [4:0] chans [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h0C, 5'h10, 5'h13};

  // Clock and open-drain data wire with pull-up
  always #20 clk = ~clk;
  assign sda = ~((sda_oe & ~sda_out) | m_oe);
  always @(posedge clk) if (adc_start_reg) starts <= starts + 1;

  mrr_top #(.BASE_CYC(BASE)) i_mrr_top (.clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .adc_start_reg(adc_start_reg), .adc_chan_reg(adc_chan_reg),
    .adc_range_reg(adc_range_reg), .adc_step_reg(adc_step_reg), .adc_begin(adc_begin),
    .adc_end(adc_end), .adc_data(adc_data), .cur_sample(cur_sample), .hv_sample(hv_sample),
    .mon_groups(mon_groups), .link_ok(link_ok));
  mrr_i2c_master i_mrr_i2c_master (.clk(clk), .sda(sda), .scl(scl), .oe(m_oe));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_mrr_i2c_master.wr(a, d, ok);
    check(16'(ok), 16'h0001);
  endtask

  task automatic rd(input logic [7:0] a);
    i_mrr_i2c_master.rd(a, d0, d1, ok);
    check(16'(ok), 16'h0001);
  endtask

  // One-cycle converter handshake pulse
  task automatic pulse(input logic fin);
    @(negedge clk);
    adc_begin = ~fin;
    adc_end = fin;
    @(negedge clk);
    adc_begin = 1'b0;
    adc_end = 1'b0;
  endtask

  function automatic logic [15:0] step_of(input logic [4:0] ch, input logic rg);
    if (ch == CH_HV) return rg ? STEP_HV_HI : STEP_HV_LO;
    return rg ? STEP_V_HI : STEP_V_LO;
  endfunction

  // Average after k samples of a constant value
  function automatic logic [9:0] avg_after(input logic [9:0] s, input int k);
    logic [12:0] acc;
    acc = 13'h0000;
    repeat (k) acc = acc - (acc >> 3) + 13'(s);
    return acc[12:3];
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    logic [31:0] r;
    logic [9:0] av;
    int s0;
    int iv;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int a = 0; a < 8; a += 2) begin
      rd(8'(a));
      check(16'({d1, d0}), 16'h0000);
    end
    check(16'(sda_out), 16'h0000);
    $display("test reset done");
    // Conversion on every legal channel, random range and spare bits
    for (int i = 0; i < 13; i++) begin
      r = $random(seed);
      s0 = starts;
      wr(ADR_ADC_SEL, {r[0], r[2:1], chans[i]});
      check(16'(starts - s0), 16'h0001);
      check({10'h000, adc_range_reg, adc_chan_reg}, {10'h000, r[0], chans[i]});
      check(adc_step_reg, step_of(chans[i], r[0]));
      rd(ADR_ADC_SEL);
      check(16'(d0), 16'({r[0], 2'b00, chans[i]}));
      check(16'(d1 & 8'h07), 16'h0004);
      pulse(1'b0);
      rd(ADR_ADC_LO);
      check(16'(d0 & 8'h07), 16'h0002);
      adc_data = r[15:3];
      pulse(1'b1);
      // Poll, bounded, until done set and active clear
      for (int p = 0; p < 4; p++) begin
        rd(ADR_ADC_LO);
        if (d0[1:0] == 2'b01) break;
      end
      check(16'({d1, d0}), 16'({r[15:3], 3'b001}));
    end
    wr(ADR_ADC_LO, 8'hFF);
    wr(ADR_ADC_HI, 8'h00);
    rd(ADR_ADC_LO);
    check(16'({d1, d0}), 16'({r[15:3], 3'b001}));
    $display("test conversion done");
    // Each sample interval with the high-voltage channel alone
    r = $random(seed);
    hv_sample = 10'(r[7:0]) | 10'h001;
    cur_sample = 10'(r[17:8]) | 10'h001;
    wr(ADR_AVG_SEL, 8'h03);
    for (int f = 0; f < 4; f++) begin
      iv = BASE << f;
      wr(ADR_AVG_CTL, 8'h00);
      wr(ADR_AVG_CTL, 8'(8'h20 | f));
      repeat (8 * iv) @(negedge clk);
      rd(ADR_AVG_LO);
      av = {d1[1:0], d0};
      check(16'(av >= avg_after(hv_sample, 7) && av <= avg_after(hv_sample, 9 + 500 / iv)), 16'h0001);
      check(16'(d1[7:2]), 16'h0000);
    end
    wr(ADR_AVG_SEL, 8'h00);
    rd(ADR_AVG_LO);
    check(16'({d1, d0}), 16'h0000);
    // Both channels settled, every readout code
    hv_sample = 10'($random(seed));
    cur_sample = 10'($random(seed));
    wr(ADR_AVG_CTL, 8'h24);
    wr(ADR_ADC_SEL, 8'h10);
    repeat (100 * BASE) @(negedge clk);
    rd(ADR_AVG_CTL);
    check(16'({d1, d0}), 16'h0024);
    for (int c = 0; c < 4; c++) begin
      wr(ADR_AVG_SEL, 8'(c));
      rd(ADR_AVG_LO);
      check(16'({d1, d0}), c == 0 ? 16'(cur_sample) : c == 3 ? 16'(hv_sample) : 16'h0000);
    end
    hv_sample = ~hv_sample;
    repeat (100 * BASE) @(negedge clk);
    rd(ADR_AVG_LO);
    check(16'({d1, d0}), 16'(hv_sample));
    $display("test averaging done");
    // Status groups, valid bit and live refresh
    wr(ADR_MON_SEL, 8'h80);
    rd(ADR_MON_SEL);
    check(16'(d0), 16'h0000);
    link_ok = 1'b1;
    for (int g = 0; g < MON_GROUPS; g++) begin
      mon_groups = MW'({$random(seed), $random(seed)});
      wr(ADR_MON_SEL, 8'(g));
      rd(ADR_MON_SEL);
      check(16'({d0, d1}), {4'h8, 4'(g), mon_groups[g*8 +: 8]});
      mon_groups = MW'({$random(seed), $random(seed)});
      rd(ADR_MON_SEL);
      check(16'(d1), 16'(mon_groups[g*8 +: 8]));
    end
    link_ok = 1'b0;
    rd(ADR_MON_SEL);
    check(16'(d0), 16'h0006);
    $display("test monitor done");
    results();
  end
endmodule
